// ==== host_port_pin_interface.sv ====
// Host port pin logic: strap capture, byte and word transfers, APB side.
`timescale 1ns/100ps
// Overview of operation
// - Select inputs route access to one register.
// - Byte id marks first/second byte, muxed only.
// - Address strobe latches address into address register.
// - Direction input chooses read or write.
// - Ready output shows port can take transfer.
// - Ready pin released when outputs disabled.
// - Interrupt pin driven high during reset.
// - Disabled port puts timer 1 on interrupt.
// - Interrupt pin released when outputs disabled.
// - Strap captured as reset is released.
// - Strap ignored after capture until next reset.
// - Wide select gives direct addressing from low eight address bits.
// - Wide mode moves whole sixteen-bit words.
// - Wide mode has no interrupt path.
// - Wide mode has no control or address register.
// - Byte bus carries data, else general I/O.
module host_port_pin_interface
    import host_port_pkg::*;
(
    // Clock and reset.
    input  wire logic                      CLK,
    input  wire logic                      ARST_N,
    // Host control pins and straps.
    input  wire host_port_pkg::host_ctl_type HOST_CTL,
    input  wire logic                      PORT_ENABLE_STRAP,
    input  wire logic                      WIDE_MODE_SELECT,
    input  wire logic                      OUTPUT_DISABLE_N,
    input  wire logic                      TIMER1_OUTPUT,
    // Byte data bus, three signals per pin.
    input  wire logic [7:0]                BYTE_DATA_BUS_IN,
    output logic [7:0]                     BYTE_DATA_BUS_OUT,
    output logic [7:0]                     BYTE_DATA_BUS_OE,
    // Wide address and data buses.
    input  wire logic [15:0]               WIDE_ADDR_BUS,
    input  wire logic [15:0]               WIDE_DATA_BUS_IN,
    output logic [15:0]                    WIDE_DATA_BUS_OUT,
    output logic                           WIDE_DATA_BUS_OE,
    // Ready and interrupt pins.
    output logic                           PORT_READY_OUT,
    output logic                           PORT_READY_OE,
    output logic                           HOST_IRQ_OUT,
    output logic                           HOST_IRQ_OE,
    // APB slave.
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [7:0]                PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic [31:0]                    PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR
);
    import host_port_pkg::*;

    // True for both select codes that reach the shared memory.
    function automatic logic is_data_sel(input logic [1:0] sel);
        is_data_sel = (sel == SEL_DATA_INC) || (sel == SEL_DATA);
    endfunction

    logic [WORD_W-1:0] mem [MEM_DEPTH];   // Shared memory words.
    xfer_state_type    state_q;           // Transfer sequencer.
    xfer_state_type    state_d;           // Its next value.
    logic              strap_done_q;      // Strap already taken.
    logic              port_en_q;         // Captured enable strap.
    logic              rd_q;              // Current transfer is a read.
    logic              as_q;              // Address strobe last cycle.
    logic [7:0]        wr_hi_q;           // First byte of a write.
    logic [15:0]       rd_word_q;         // Word held for second byte.
    logic [15:0]       addr_q;            // Host address register.
    logic              h2d_q;             // Host to device flag.
    logic              d2h_q;             // Device to host flag.
    logic [7:0]        byte_out_q;        // Byte driven on reads.
    logic [15:0]       wide_out_q;        // Word driven on reads.
    logic              ready_q;           // Ready pin value.
    logic              irq_q;             // Interrupt pin value.
    logic [7:0]        gpio_out_q;        // General I/O out values.
    logic [7:0]        gpio_oe_q;         // General I/O enables.
    logic [7:0]        mem_addr_q;        // APB memory pointer.
    logic [31:0]       prdata_q;          // Registered read data.
    logic [15:0]       ctrl_word;         // Control register image.
    logic [31:0]       apb_rd;            // APB read selection.

    // Decoded host pin state.
    wire logic [1:0] reg_sel = {HOST_CTL.reg_select_bit1,
                                HOST_CTL.reg_select_bit0};
    wire logic port_on  = port_en_q & strap_done_q;
    wire logic wide     = WIDE_MODE_SELECT;
    wire logic selected = ~HOST_CTL.port_select_n;
    wire logic strobe_now = selected & (~HOST_CTL.data_strobe_a_n
                          | ~HOST_CTL.data_strobe_b_n);
    wire logic start = port_on & strobe_now
                     & (state_q == ST_IDLE);
    wire logic is_read = HOST_CTL.transfer_direction;
    // The byte id only matters with the byte bus in use.
    wire logic second = ~wide & HOST_CTL.byte_order_id;
    wire logic mux_wr_word = start & ~wide & ~is_read & second;
    wire logic wide_wr = start & wide & ~is_read;
    wire logic [15:0] host_wr_word = {wr_hi_q, BYTE_DATA_BUS_IN};
    wire logic host_mem_we = (mux_wr_word & is_data_sel(reg_sel))
                           | wide_wr;
    wire logic [MEM_AW-1:0] host_mem_addr = wide
        ? WIDE_ADDR_BUS[MEM_AW-1:0] : addr_q[MEM_AW-1:0];
    wire logic [15:0] host_mem_wdata = wide ? WIDE_DATA_BUS_IN
                                            : host_wr_word;
    wire logic [15:0] host_mem_rd = mem[host_mem_addr];
    wire logic ctrl_wr = mux_wr_word & (reg_sel == SEL_CTRL);
    wire logic addr_wr = mux_wr_word & (reg_sel == SEL_ADDR);
    wire logic auto_inc = start & second
                        & (reg_sel == SEL_DATA_INC);
    wire logic as_now = port_on & ~wide & selected
                      & ~HOST_CTL.addr_strobe_n;
    wire logic as_fall = as_now & ~as_q;
    wire logic [15:0] rd_src = (reg_sel == SEL_CTRL) ? ctrl_word
                             : (reg_sel == SEL_ADDR) ? addr_q
                             : host_mem_rd;
    wire logic rd_drive = rd_q & (state_q != ST_IDLE);

    // APB decode.
    wire logic apb_setup = PSEL & ~PENABLE;
    wire logic apb_access = PSEL & PENABLE;
    wire logic apb_known = (PADDR == APB_CTRL) || (PADDR == APB_STATUS)
        || (PADDR == APB_GPIO_OUT) || (PADDR == APB_GPIO_OE)
        || (PADDR == APB_GPIO_IN) || (PADDR == APB_MEM_ADDR)
        || (PADDR == APB_MEM_DATA);
    wire logic apb_mem_hit = PWRITE & (PADDR == APB_MEM_DATA);
    wire logic apb_we = apb_access & PWRITE & PREADY & apb_known;
    wire logic apb_mem_we = apb_we & (PADDR == APB_MEM_DATA);
    wire logic d2h_set = apb_we & (PADDR == APB_CTRL) & PWDATA[0]
                       & ~wide;
    wire logic d2h_clr = ctrl_wr & host_wr_word[CTRL_D2H_BIT];
    wire logic h2d_set = ctrl_wr & host_wr_word[CTRL_H2D_BIT];
    wire logic h2d_clr = apb_we & (PADDR == APB_STATUS) & PWDATA[0];

    // A host memory write holds off a colliding APB memory write.
    assign PREADY  = ~(host_mem_we & apb_mem_hit);
    assign PSLVERR = apb_access & ~apb_known;
    assign PRDATA  = prdata_q;

    // Control register image as the host reads it.
    always_comb
    begin
        ctrl_word = 16'h0000;
        ctrl_word[CTRL_H2D_BIT] = h2d_q;
        ctrl_word[CTRL_D2H_BIT] = d2h_q;
    end

    // APB read selection, taken in the setup cycle.
    always_comb
    begin
        apb_rd = 32'h0000_0000;
        case (PADDR)
            APB_STATUS:   apb_rd = {28'h0000000, wide, port_on,
                                    d2h_q, h2d_q};
            APB_GPIO_OUT: apb_rd = {24'h000000, gpio_out_q};
            APB_GPIO_OE:  apb_rd = {24'h000000, gpio_oe_q};
            APB_GPIO_IN:  apb_rd = {24'h000000, BYTE_DATA_BUS_IN};
            APB_MEM_ADDR: apb_rd = {24'h000000, mem_addr_q};
            APB_MEM_DATA: apb_rd = {16'h0000, mem[mem_addr_q]};
            default:      apb_rd = 32'h0000_0000;
        endcase
    end

    // Sequencer: take on a strobe, answer, then wait for release.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (start) state_d = ST_BUSY;
            ST_BUSY: state_d = ST_HOLD;
            ST_HOLD: if (!strobe_now) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // The strap is caught by the first edge after reset release; the
    // flop itself only resets to a constant.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            strap_done_q <= 1'b0;
            port_en_q    <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
            port_en_q    <= PORT_ENABLE_STRAP;
        end
    end

    // Sequencer, ready pin and strobe history.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            as_q    <= 1'b0;
            rd_q    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ready_q <= port_on & (state_d == ST_IDLE);
            as_q    <= as_now;
            if (start)
                rd_q <= is_read;
        end
    end

    // Host address register: strobe load, word write, increment.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            addr_q <= ADDR_RST;
        else if (as_fall)
        begin
            // The byte id picks which half the strobe loads.
            if (HOST_CTL.byte_order_id)
                addr_q[7:0] <= BYTE_DATA_BUS_IN;
            else
                addr_q[15:8] <= BYTE_DATA_BUS_IN;
        end
        else if (addr_wr)
            addr_q <= host_wr_word;
        else if (auto_inc)
            addr_q <= addr_q + 16'h0001;
    end

    // Byte pairing and read data flops.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wr_hi_q    <= 8'h00;
            rd_word_q  <= 16'h0000;
            byte_out_q <= 8'h00;
            wide_out_q <= 16'h0000;
        end
        else if (start && !wide)
        begin
            if (!is_read && !second)
                wr_hi_q <= BYTE_DATA_BUS_IN;
            if (is_read && !second)
            begin
                rd_word_q  <= rd_src;
                byte_out_q <= rd_src[15:8];
            end
            else if (is_read)
                byte_out_q <= rd_word_q[7:0];
        end
        else if (start && is_read)
            wide_out_q <= host_mem_rd;
    end

    // Interrupt flags; a set in the same cycle as a clear wins.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            h2d_q <= 1'b0;
            d2h_q <= 1'b0;
        end
        else
        begin
            h2d_q <= h2d_set | (h2d_q & ~h2d_clr);
            d2h_q <= d2h_set | (d2h_q & ~d2h_clr);
        end
    end

    // Interrupt pin: high in reset, timer 1 when the port is off.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            irq_q <= IRQ_PIN_RST;
        else if (!port_on)
            irq_q <= TIMER1_OUTPUT;
        else
            irq_q <= wide | ~d2h_q;
    end

    // APB side registers and registered read data.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            gpio_out_q <= 8'h00;
            gpio_oe_q  <= 8'h00;
            mem_addr_q <= 8'h00;
            prdata_q   <= 32'h0000_0000;
        end
        else
        begin
            if (apb_setup)
                prdata_q <= apb_rd;
            if (apb_we && PADDR == APB_GPIO_OUT)
                gpio_out_q <= PWDATA[7:0];
            if (apb_we && PADDR == APB_GPIO_OE)
                gpio_oe_q <= PWDATA[7:0];
            if (apb_we && PADDR == APB_MEM_ADDR)
                mem_addr_q <= PWDATA[7:0];
        end
    end

    // Single write port; the host has priority over APB.
    always_ff @(posedge CLK)
    begin
        if (host_mem_we)
            mem[host_mem_addr] <= host_mem_wdata;
        else if (apb_mem_we)
            mem[mem_addr_q] <= PWDATA[15:0];
    end

    // Byte bus pins: data on reads, general I/O in wide mode.
    for (genvar i = 0; i < BYTE_W; i++)
    begin : g_byte_pin
        assign BYTE_DATA_BUS_OUT[i] = wide ? gpio_out_q[i]
                                           : byte_out_q[i];
        assign BYTE_DATA_BUS_OE[i] = OUTPUT_DISABLE_N
            & (wide ? gpio_oe_q[i] : rd_drive);
    end

    // Wide data bus and the two status pins.
    assign WIDE_DATA_BUS_OUT = wide_out_q;
    assign WIDE_DATA_BUS_OE  = OUTPUT_DISABLE_N & wide & rd_drive;
    assign PORT_READY_OUT    = ready_q;
    assign PORT_READY_OE     = OUTPUT_DISABLE_N;
    assign HOST_IRQ_OUT      = irq_q;
    assign HOST_IRQ_OE       = OUTPUT_DISABLE_N;
endmodule

// ==== host_port_pkg.sv ====
// Constants, types and register map shared by the host port design.
package host_port_pkg;
    // Widths and memory size.
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    // Register select codes seen on the two select inputs.
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;
    // Field positions in the host control register.
    localparam int CTRL_H2D_BIT = 1;
    localparam int CTRL_D2H_BIT = 2;
    // APB byte offsets.
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_GPIO_OUT = 8'h08;
    localparam logic [7:0] APB_GPIO_OE = 8'h0c;
    localparam logic [7:0] APB_GPIO_IN = 8'h10;
    localparam logic [7:0] APB_MEM_ADDR = 8'h14;
    localparam logic [7:0] APB_MEM_DATA = 8'h18;
    // Values after reset.
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic IRQ_PIN_RST = 1'b1;
    // Transfer sequencer, Gray coded along idle, busy, hold.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BUSY = 2'h1,
        ST_HOLD = 2'h3
    } xfer_state_type;
    // Host control pins; strobes are active low, direction 1 = read.
    typedef struct packed {
        logic reg_select_bit1;
        logic reg_select_bit0;
        logic byte_order_id;
        logic port_select_n;
        logic data_strobe_a_n;
        logic data_strobe_b_n;
        logic addr_strobe_n;
        logic transfer_direction;
    } host_ctl_type;
endpackage

// ==== host_port_checker.sv ====
// Timing checker for the host port pins, bound to the top module.
`timescale 1ns/100ps
module host_port_checker
    import host_port_pkg::*;
(
    // Clock and reset.
    input wire logic                        CLK,
    input wire logic                        ARST_N,
    // Host pins and mode inputs.
    input wire host_port_pkg::host_ctl_type HOST_CTL,
    input wire logic                        WIDE_MODE_SELECT,
    input wire logic                        OUTPUT_DISABLE_N,
    // Pin drivers of the port.
    input wire logic [7:0]                  BYTE_DATA_BUS_OE,
    input wire logic                        WIDE_DATA_BUS_OE,
    input wire logic                        PORT_READY_OUT,
    input wire logic                        PORT_READY_OE,
    input wire logic                        HOST_IRQ_OUT,
    input wire logic                        HOST_IRQ_OE
);
    logic act; // Host holds a selected strobe.
    logic go;  // The port accepts it at this edge.
    assign act = !HOST_CTL.port_select_n &&
                 !(HOST_CTL.data_strobe_a_n && HOST_CTL.data_strobe_b_n);
    assign go = act && PORT_READY_OUT;
    // One clock domain, so clock and reset are named once.
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_ready_off:
        assert property (!OUTPUT_DISABLE_N |-> !PORT_READY_OE)
        else $error("Ready pin driven while outputs are off.");
    a_irq_off:
        assert property (!OUTPUT_DISABLE_N |-> !HOST_IRQ_OE)
        else $error("Interrupt pin driven while outputs are off.");
    a_irq_in_reset:
        assert property ($rose(ARST_N) |-> HOST_IRQ_OUT)
        else $error("Interrupt pin not high out of reset.");
    a_ready_drop:
        assert property (go |=> !PORT_READY_OUT)
        else $error("Ready stayed high after a taken transfer.");
    a_ready_hold:
        assert property (act && !PORT_READY_OUT |=> !PORT_READY_OUT)
        else $error("Ready rose while the strobe is held.");
    a_read_drive:
        assert property (go && HOST_CTL.transfer_direction && !WIDE_MODE_SELECT
            |=> !OUTPUT_DISABLE_N || BYTE_DATA_BUS_OE == 8'hff)
        else $error("Byte bus not driven for a host read.");
    a_write_quiet:
        assert property (go && !HOST_CTL.transfer_direction
            && !WIDE_MODE_SELECT |=> BYTE_DATA_BUS_OE == 8'h00)
        else $error("Byte bus driven during a host write.");
    a_wide_read:
        assert property (go && HOST_CTL.transfer_direction && WIDE_MODE_SELECT
            |=> !OUTPUT_DISABLE_N || WIDE_DATA_BUS_OE)
        else $error("Wide bus not driven for a host read.");
    a_idle_quiet:
        assert property (!WIDE_MODE_SELECT && PORT_READY_OUT
            |-> BYTE_DATA_BUS_OE == 8'h00)
        else $error("Byte bus driven while the port is idle.");
    a_wide_no_irq:
        assert property (WIDE_MODE_SELECT && $past(WIDE_MODE_SELECT)
            && PORT_READY_OUT |-> HOST_IRQ_OUT)
        else $error("Interrupt asserted in wide mode.");
endmodule
bind host_port_pin_interface host_port_checker chk (.CLK, .ARST_N,
    .HOST_CTL, .WIDE_MODE_SELECT, .OUTPUT_DISABLE_N, .BYTE_DATA_BUS_OE,
    .WIDE_DATA_BUS_OE, .PORT_READY_OUT, .PORT_READY_OE, .HOST_IRQ_OUT,
    .HOST_IRQ_OE);

// ==== host_model.sv ====
// Behavioural host processor driving the port pins.
`timescale 1ns/100ps
module host_model
    import host_port_pkg::*;
(
    // Clock and ready from the port.
    input  wire logic                   clk,
    input  wire logic                   ready,
    // Control pins.
    output host_port_pkg::host_ctl_type ctl,
    // Byte and wide buses, resolved here.
    input  wire logic [7:0]             b_out,
    input  wire logic [7:0]             b_oe,
    output logic [7:0]                  b_pin,
    output logic [15:0]                 w_addr,
    input  wire logic [15:0]            w_out,
    input  wire logic                   w_oe,
    output logic [15:0]                 w_pin
);
    logic [15:0] hv = 16'h0000; // Host drive; inverted when released.
    logic        desel = 1'b0;  // Set by a scenario to leave select high.
    initial ctl = 8'h1f;
    initial w_addr = 16'h0000;
    // A released line shows the inverse of the last value, never a copy.
    assign b_pin = (b_oe & b_out) | (~b_oe & hv[7:0]);
    assign w_pin = w_oe ? w_out : hv;
    // Bounded wait so a stuck port cannot hang the host.
    task automatic wait_ready();
        int n;
        for (n = 0; n < 64 && ready !== 1'b1; n++)
            @(posedge clk);
    endtask
    // One strobed transfer; the byte id picks which strobe is used.
    task automatic xfer(input logic [1:0] sel, input logic id, dir,
                        input logic [15:0] a, d, output logic [15:0] rd);
        wait_ready();
        ctl <= {sel, id,
                desel,
                id, ~id, 1'b1,
                dir};
        w_addr <= a;
        hv <= dir ? ~hv : d;
        repeat (3) @(posedge clk);
        rd = w_oe ? w_pin : {8'h00, b_pin};
        ctl <= {sel, id, 4'hf, dir};
        hv <= ~hv;
        @(posedge clk);
        wait_ready();
    endtask
    // Address strobe pulse carrying one address byte.
    task automatic astb(input logic id, input logic [7:0] a);
        wait_ready();
        ctl <= {SEL_ADDR, id, 4'h6, 1'b0};
        hv <= {8'h00, a};
        repeat (2) @(posedge clk);
        ctl <= {SEL_ADDR, id, 4'hf, 1'b0};
        hv <= ~hv;
        @(posedge clk);
    endtask
endmodule

// ==== host_port_pin_interface_test.sv ====
// Self-checking bench for the host port pin logic.
`timescale 1ns/100ps
module host_port_pin_interface_test;
    import host_port_pkg::*;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         strap = 1'b1;
    logic         wide = 1'b0;
    logic         oen = 1'b1;
    logic         tmr = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata, rdv;
    logic         pready, pslverr, perr;
    host_ctl_type ctl;
    logic [7:0]   b_pin, b_out, b_oe;
    logic [15:0]  w_addr, w_pin, w_out, a, w, w2, r;
    logic         w_oe, rdy, rdy_oe, irq, irq_oe;
    logic [1:0]   s;
    int           error_cnt = 0;
    int           n_checks = 0;
    int           i;
    integer       seed = 32'h4324;
    always #2.5 clk = ~clk;
    host_port_pin_interface dut (.CLK(clk), .ARST_N(arst_n), .HOST_CTL(ctl),
        .PORT_ENABLE_STRAP(strap), .WIDE_MODE_SELECT(wide),
        .OUTPUT_DISABLE_N(oen), .TIMER1_OUTPUT(tmr), .BYTE_DATA_BUS_IN(b_pin),
        .BYTE_DATA_BUS_OUT(b_out), .BYTE_DATA_BUS_OE(b_oe),
        .WIDE_ADDR_BUS(w_addr), .WIDE_DATA_BUS_IN(w_pin),
        .WIDE_DATA_BUS_OUT(w_out), .WIDE_DATA_BUS_OE(w_oe),
        .PORT_READY_OUT(rdy), .PORT_READY_OE(rdy_oe), .HOST_IRQ_OUT(irq),
        .HOST_IRQ_OE(irq_oe), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));
    host_model host (.clk(clk), .ready(rdy), .ctl(ctl), .b_out(b_out),
        .b_oe(b_oe), .b_pin(b_pin), .w_addr(w_addr), .w_out(w_out),
        .w_oe(w_oe), .w_pin(w_pin));
    // Expected status word from the flags.
    // Bit order: wide mode, port enabled, device flag, host flag.
    function automatic logic [31:0] status_exp(input int h, e, d, m);
        return {28'h0, m[0], e[0], d[0], h[0]};
    endfunction
    // Memory word that an auto-increment select moves on to.
    function automatic logic [31:0] nxt(input logic [1:0] sl,
                                        input logic [15:0] ad);
        return {24'h0, ad[7:0] + {7'h0, sl == SEL_DATA_INC}};
    endfunction
    // Compare and count.
    task automatic chk(input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; read data lands in rdv, the error flag in perr.
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait for the slave's answer.
        while (pready !== 1'b1)
            @(posedge clk);
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // A word as two byte transfers, high byte first.
    task automatic hword(input logic [1:0] sl, input logic dir,
                         input logic [15:0] d, output logic [15:0] rd);
        logic [15:0] h, l;
        host.xfer(sl, 1'b0, dir, 16'h0, {8'h00, d[15:8]}, h);
        host.xfer(sl, 1'b1, dir, 16'h0, {8'h00, d[7:0]}, l);
        rd = {h[7:0], l[7:0]};
    endtask
    // Reset with a strap level; the strap flips once it has been taken.
    task automatic do_reset(input logic st);
        arst_n <= 1'b0;
        strap <= st;
        repeat (6) @(posedge clk);
        chk(irq, 1'b1);
        arst_n <= 1'b1;
        @(posedge clk);
        strap <= ~st;
        repeat (3) @(posedge clk);
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence: muxed words, control flags, wide mode, disabled port.
    initial
    begin
        do_reset(1'b1);
        chk(rdy, 1'b1);
        for (i = 0; i < 8; i++)
        begin
            a = 16'($random(seed));
            w = 16'($random(seed));
            w2 = 16'($random(seed));
            s = i[0] ? SEL_DATA_INC : SEL_DATA;
            // Address comes either by strobe or by register write.
            if (i[1])
            begin
                host.astb(1'b0, a[15:8]);
                host.astb(1'b1, a[7:0]);
            end
            else
                hword(SEL_ADDR, 1'b0, a, r);
            hword(s, 1'b0, w, r);
            hword(SEL_DATA_INC, 1'b0, w2, r);
            apb(1'b1, APB_MEM_ADDR, {24'h0, a[7:0]});
            apb(1'b0, APB_MEM_DATA, 32'h0);
            chk(rdv, s == SEL_DATA_INC ? w : w2);
            apb(1'b1, APB_MEM_ADDR, nxt(s, a));
            apb(1'b0, APB_MEM_DATA, 32'h0);
            chk(rdv, w2);
            hword(SEL_ADDR, 1'b0, a, r);
            hword(s, 1'b1, 16'h0, r);
            chk(r, s == SEL_DATA_INC ? w : w2);
        end
        apb(1'b1, APB_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        hword(SEL_CTRL, 1'b1, 16'h0, r);
        chk(r & 16'h0004, 16'h0004);
        hword(SEL_CTRL, 1'b0, 16'h0006, r);
        apb(1'b0, APB_STATUS, 32'h0);
        chk({irq, rdv}, {1'b1, status_exp(1, 1, 0, 0)});
        apb(1'b1, APB_STATUS, 32'h1);
        // A deselected write must leave memory alone.
        hword(SEL_ADDR, 1'b0, a, r);
        host.desel = 1'b1;
        hword(SEL_DATA, 1'b0, ~w, r);
        host.desel = 1'b0;
        apb(1'b1, APB_MEM_ADDR, {24'h0, a[7:0]});
        apb(1'b0, APB_MEM_DATA, 32'h0);
        chk(rdv, w);
        oen <= 1'b0;
        repeat (2) @(posedge clk);
        chk({rdy_oe, irq_oe}, 2'b00);
        oen <= 1'b1;
        wide <= 1'b1;
        @(posedge clk);
        host.xfer(SEL_DATA, 1'b0, 1'b0, a, w2, r);
        apb(1'b0, APB_MEM_DATA, 32'h0);
        chk(rdv, w2);
        host.xfer(SEL_DATA, 1'b1, 1'b1, a, 16'h0, r);
        chk(r, w2);
        apb(1'b1, APB_CTRL, 32'h1);
        apb(1'b1, APB_GPIO_OUT, {24'h0, a[15:8]});
        apb(1'b1, APB_GPIO_OE, 32'hff);
        apb(1'b0, APB_STATUS, 32'h0);
        chk({irq, rdv}, {1'b1, status_exp(0, 1, 0, 1)});
        chk({b_oe, b_out}, {8'hff, a[15:8]});
        apb(1'b0, APB_GPIO_IN, 32'h0);
        chk(rdv, {24'h0, a[15:8]});
        apb(1'b1, APB_GPIO_OE, 32'h0);
        wide <= 1'b0;
        // Unmapped offset: error flag, read as zero.
        apb(1'b1, 8'h40, 32'hffffffff);
        apb(1'b0, 8'h40, 32'h0);
        chk({perr, rdv}, {1'b1, 32'h0});
        do_reset(1'b0);
        apb(1'b0, APB_STATUS, 32'h0);
        chk({rdy, rdv}, {1'b0, status_exp(0, 0, 0, 0)});
        for (i = 0; i < 6; i++)
        begin
            tmr <= 1'($random(seed));
            repeat (2) @(posedge clk);
            chk(irq, tmr);
        end
        final_report();
    end
    // Watchdog well beyond the expected run length.
    initial
    begin
        #60000;
        error_cnt++;
        final_report();
    end
endmodule
